// [src/vcw_pkg.sv]
// Notes on behaviour
// - command strobe latches bits 4 to 23
// - command holds address and package select
// - bus and output strobe to both units
// - each strobe echoed as accepted pulse
// - command bits 19-23: convert, input pick
// - 200 ns delay, 5 us settle, convert
// - busy while converting, then 10-bit result
// - busy fall sets flag, ack clears
// - master clear zeroes words; inverted pulse bits drive 1
// - eight 24-bit words per unit, driven
// - units differ only in package bit
// - mode picks address and package source
// - decode only with own package bit
// - only enabled word stores on load
// - manual switches, load on release
// - manual load button debounced
// - panel reset holds words at zero
// - warning lit outside computer mode
// - external source never loads
// - 500 ns after load, 1 us pulses
// - three pulse bits per word, polarity
package vcw_pkg;

    // ************
    // timing
    // ************
    localparam int CLK_NS = 100;
    localparam int CMD_DLY_NS = 200;
    localparam int SETTLE_NS = 5000;
    localparam int PLS_DLY_NS = 500;
    localparam int PLS_WID_NS = 1000;
    localparam int DEB_NS = 2000;
    localparam logic [7:0] CMD_DLY_CYC = 8'((CMD_DLY_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] SETTLE_CYC = 8'((SETTLE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] PLS_DLY_CYC = 4'((PLS_DLY_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] PLS_WID_CYC = 4'(PLS_WID_NS / CLK_NS);
    localparam logic [7:0] DEB_CYC = 8'((DEB_NS + CLK_NS - 1) / CLK_NS);

    // ************
    // command word fields
    // ************
    localparam int CMD_LO = 4;
    localparam int CMD_HI = 23;
    localparam int WADR_LSB = 4;
    localparam int PSEL_LSB = 8;
    localparam int CONV_BIT = 19;
    localparam int AMUX_LSB = 20;
    localparam int RES_W = 10;

    // ************
    // source modes and unit wiring
    // ************
    localparam logic [1:0] MODE_COMPUTER = 2'h0;
    localparam logic [1:0] MODE_MANUAL = 2'h1;
    localparam int UNIT0_PSEL_BIT = 0;
    localparam int UNIT1_PSEL_BIT = 1;

    // ************
    // register map
    // ************
    localparam logic [7:0] ADR_STATUS = 8'h00;
    localparam logic [7:0] ADR_RESULT = 8'h04;
    localparam logic [1:0] PAGE_PCFG = 2'h1;
    localparam logic [1:0] PAGE_WORD = 2'h2;
    localparam logic [20:0] PCFG_RST = 21'h000000;
    localparam int SLOT_W = 7;
    localparam int SLOT_EN = 5;
    localparam int SLOT_INV = 6;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [1:0] mode;
        logic [23:0] data;
        logic [2:0] addr;
        logic load;
        logic clr;
    } vcw_panel_type;

    typedef struct packed {
        logic [23:0] data;
        logic [2:0] addr;
        logic [3:0] psel;
    } vcw_ext_type;

    typedef enum logic [2:0] {
        ADC_IDLE = 3'b000,
        ADC_CMD = 3'b001,
        ADC_SETTLE = 3'b010,
        ADC_WAITB = 3'b011,
        ADC_CONV = 3'b100
    } vcw_adc_state_type;

endpackage

// [src/vcw_top.sv]
// Our own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns
module vcw_top (
    input wire logic clk, // clock
    input wire logic sys_rst, // sync reset
    input wire logic ce, // clock enable
    input wire logic [23:0] host_out_bus, // host data
    input wire logic command_word_strobe, // command marker
    input wire logic output_word_strobe, // data marker
    input wire logic host_input_ack, // result taken
    input wire logic host_master_clear, // master clear
    output logic transfer_accepted_pulse, // strobe echo
    output logic input_ready_flag, // result waiting
    output logic [23:0] host_in_bus, // result
    output logic [3:0] adc_mux_sel, // input select
    output logic adc_start, // start
    input wire logic adc_busy, // busy
    input wire logic [9:0] adc_result, // raw result
    input wire vcw_pkg::vcw_panel_type [1:0] panel_in, // panels
    input wire vcw_pkg::vcw_ext_type ext_in, // external
    output logic [1:0] warn_lamp, // lamps
    output logic [1:0][7:0][23:0] ctl_out, // control bits
    input wire logic [7:0] s_axi_awaddr, // aw addr
    input wire logic s_axi_awvalid, // aw valid
    output logic s_axi_awready, // aw ready
    input wire logic [31:0] s_axi_wdata, // w data
    input wire logic [3:0] s_axi_wstrb, // w strobes
    input wire logic s_axi_wvalid, // w valid
    output logic s_axi_wready, // w ready
    output logic [1:0] s_axi_bresp, // b resp
    output logic s_axi_bvalid, // b valid
    input wire logic s_axi_bready, // b ready
    input wire logic [7:0] s_axi_araddr, // ar addr
    input wire logic s_axi_arvalid, // ar valid
    output logic s_axi_arready, // ar ready
    output logic [31:0] s_axi_rdata, // r data
    output logic [1:0] s_axi_rresp, // r resp
    output logic s_axi_rvalid, // r valid
    input wire logic s_axi_rready // r ready
);
    import vcw_pkg::*;

    // ************
    // functions
    // ************
    function automatic logic [20:0] merge_bytes(input logic [20:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0] strb);
        logic [31:0] r;
        r = {11'h000, old_v};
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return r[20:0];
    endfunction

    function automatic logic rising(input logic now_v, input logic was_v);
        return now_v & ~was_v;
    endfunction

    // ************
    // host strobes and command latch
    // ************
    logic cmd_q_ff;
    logic out_q_ff;
    logic busy_q_ff;
    logic [CMD_HI:CMD_LO] cmd_ff;
    logic tap_ff;
    logic ready_ff;
    logic [23:0] hin_ff;
    wire cmd_rise = rising(command_word_strobe, cmd_q_ff);
    wire out_rise = rising(output_word_strobe, out_q_ff);
    wire busy_fall = busy_q_ff & ~adc_busy;
    wire [2:0] comp_wadr = cmd_ff[WADR_LSB +: 3];
    wire [3:0] comp_psel = cmd_ff[PSEL_LSB +: 4];
    wire conv_req = cmd_ff[CONV_BIT];

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cmd_q_ff <= 1'b0;
            out_q_ff <= 1'b0;
            busy_q_ff <= 1'b0;
        end else if (ce) begin
            cmd_q_ff <= command_word_strobe;
            out_q_ff <= output_word_strobe;
            busy_q_ff <= adc_busy;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cmd_ff <= '0;
        end else if (ce && command_word_strobe) begin
            cmd_ff <= host_out_bus[CMD_HI:CMD_LO];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tap_ff <= 1'b0;
        end else if (ce) begin
            tap_ff <= cmd_rise | out_rise;
        end
    end

    // ************
    // conversion sequencer
    // ************
    vcw_adc_state_type adc_st_ff;
    vcw_adc_state_type nxt_adc_st;
    logic [7:0] adc_cnt_ff;
    logic [7:0] nxt_adc_cnt;
    logic adc_start_ff;
    logic nxt_adc_start;

    always_comb begin
        nxt_adc_st = adc_st_ff;
        nxt_adc_cnt = adc_cnt_ff;
        nxt_adc_start = 1'b0;
        case (adc_st_ff)
            ADC_IDLE: begin
                nxt_adc_st = ADC_IDLE;
            end
            ADC_CMD: begin
                if (adc_cnt_ff <= 8'h01) begin
                    nxt_adc_st = conv_req ? ADC_SETTLE : ADC_IDLE;
                    nxt_adc_cnt = SETTLE_CYC;
                end else begin
                    nxt_adc_cnt = adc_cnt_ff - 8'h01;
                end
            end
            ADC_SETTLE: begin
                if (adc_cnt_ff <= 8'h01) begin
                    nxt_adc_st = ADC_WAITB;
                    nxt_adc_start = 1'b1;
                end else begin
                    nxt_adc_cnt = adc_cnt_ff - 8'h01;
                end
            end
            ADC_WAITB: begin
                if (adc_busy) begin
                    nxt_adc_st = ADC_CONV;
                end
            end
            ADC_CONV: begin
                if (busy_fall) begin
                    nxt_adc_st = ADC_IDLE;
                end
            end
            default: begin
                nxt_adc_st = ADC_IDLE;
            end
        endcase
        // new command restarts
        if (cmd_rise) begin
            nxt_adc_st = ADC_CMD;
            nxt_adc_cnt = CMD_DLY_CYC;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            adc_st_ff <= ADC_IDLE;
            adc_cnt_ff <= 8'h00;
            adc_start_ff <= 1'b0;
        end else if (ce) begin
            adc_st_ff <= nxt_adc_st;
            adc_cnt_ff <= nxt_adc_cnt;
            adc_start_ff <= nxt_adc_start;
        end
    end

    wire conv_done = (adc_st_ff == ADC_CONV) && busy_fall;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ready_ff <= 1'b0;
            hin_ff <= 24'h000000;
        end else if (ce) begin
            if (conv_done) begin
                ready_ff <= 1'b1;
                hin_ff <= {14'h0000, adc_result};
            end else if (host_input_ack) begin
                ready_ff <= 1'b0;
            end
        end
    end

    assign adc_mux_sel = cmd_ff[AMUX_LSB +: 4];
    assign adc_start = adc_start_ff;
    assign transfer_accepted_pulse = tap_ff;
    assign input_ready_flag = ready_ff;
    assign host_in_bus = hin_ff;

    // ************
    // word latch units
    // ************
    logic [23:0] word_ff [0:1][0:7];
    logic [20:0] pcfg_ff [0:15];
    logic [1:0] deb_ff;
    logic [7:0] deb_cnt_ff [0:1];
    logic [3:0] dly_cnt_ff [0:1];
    logic [3:0] pw_cnt_ff [0:1];
    logic [2:0] pw_word_ff [0:1];
    logic [2:0] hit_ff [0:1];
    logic [1:0] warn_ff;
    logic [1:0][7:0][23:0] out_ff;
    logic [2:0] sel_adr [0:1];
    logic [3:0] sel_psel [0:1];
    logic [23:0] sel_data [0:1];
    logic [1:0] load_clk;
    logic [1:0] psel_hit;
    logic [1:0] man_load;
    logic [1:0][7:0][23:0] nxt_out;
    wire [1:0][1:0] unit_psel_bit = {2'(UNIT1_PSEL_BIT), 2'(UNIT0_PSEL_BIT)};
    wire clear_all = host_master_clear;

    always_comb begin
        for (int u = 0; u < 2; u++) begin
            man_load[u] = deb_ff[u] & ~panel_in[u].load & (deb_cnt_ff[u] >= DEB_CYC);
            case (panel_in[u].mode)
                MODE_COMPUTER: begin
                    sel_adr[u] = comp_wadr;
                    sel_psel[u] = comp_psel;
                    sel_data[u] = host_out_bus;
                    load_clk[u] = out_rise;
                end
                MODE_MANUAL: begin
                    sel_adr[u] = panel_in[u].addr;
                    sel_psel[u] = 4'hF;
                    sel_data[u] = panel_in[u].data;
                    load_clk[u] = man_load[u];
                end
                default: begin
                    sel_adr[u] = ext_in.addr;
                    sel_psel[u] = ext_in.psel;
                    sel_data[u] = ext_in.data;
                    load_clk[u] = 1'b0;
                end
            endcase
            // decode only with own package bit
            psel_hit[u] = sel_psel[u][unit_psel_bit[u]];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            deb_ff <= 2'h0;
            for (int u = 0; u < 2; u++) begin
                deb_cnt_ff[u] <= 8'h00;
            end
        end else if (ce) begin
            for (int u = 0; u < 2; u++) begin
                if (panel_in[u].load == deb_ff[u]) begin
                    deb_cnt_ff[u] <= 8'h00;
                end else if (deb_cnt_ff[u] >= DEB_CYC) begin
                    deb_ff[u] <= panel_in[u].load;
                    deb_cnt_ff[u] <= 8'h00;
                end else begin
                    deb_cnt_ff[u] <= deb_cnt_ff[u] + 8'h01;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int u = 0; u < 2; u++) begin
                for (int w = 0; w < 8; w++) begin
                    word_ff[u][w] <= 24'h000000;
                end
            end
        end else if (ce) begin
            for (int u = 0; u < 2; u++) begin
                for (int w = 0; w < 8; w++) begin
                    if (clear_all || panel_in[u].clr) begin
                        word_ff[u][w] <= 24'h000000;
                    end else if (load_clk[u] && psel_hit[u] && sel_adr[u] == 3'(w)) begin
                        word_ff[u][w] <= sel_data[u];
                    end
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int u = 0; u < 2; u++) begin
                dly_cnt_ff[u] <= 4'h0;
                pw_cnt_ff[u] <= 4'h0;
                pw_word_ff[u] <= 3'h0;
                hit_ff[u] <= 3'h0;
            end
        end else if (ce) begin
            for (int u = 0; u < 2; u++) begin
                if (clear_all || panel_in[u].clr) begin
                    dly_cnt_ff[u] <= 4'h0;
                    pw_cnt_ff[u] <= 4'h0;
                    hit_ff[u] <= 3'h0;
                end else if (load_clk[u] && psel_hit[u]) begin
                    dly_cnt_ff[u] <= PLS_DLY_CYC;
                    pw_cnt_ff[u] <= 4'h0;
                    pw_word_ff[u] <= sel_adr[u];
                    hit_ff[u] <= 3'h0;
                end else if (dly_cnt_ff[u] == 4'h1) begin
                    dly_cnt_ff[u] <= 4'h0;
                    pw_cnt_ff[u] <= PLS_WID_CYC;
                    for (int k = 0; k < 3; k++) begin
                        hit_ff[u][k] <= pcfg_ff[8*u + 32'(pw_word_ff[u])][SLOT_W*k + SLOT_EN]
                            & word_ff[u][pw_word_ff[u]][pcfg_ff[8*u + 32'(pw_word_ff[u])][SLOT_W*k +: 5]];
                    end
                end else begin
                    if (dly_cnt_ff[u] != 4'h0) begin
                        dly_cnt_ff[u] <= dly_cnt_ff[u] - 4'h1;
                    end
                    if (pw_cnt_ff[u] != 4'h0) begin
                        pw_cnt_ff[u] <= pw_cnt_ff[u] - 4'h1;
                    end
                    if (pw_cnt_ff[u] == 4'h1) begin
                        hit_ff[u] <= 3'h0;
                    end
                end
            end
        end
    end

    always_comb begin
        for (int u = 0; u < 2; u++) begin
            for (int w = 0; w < 8; w++) begin
                nxt_out[u][w] = word_ff[u][w];
                for (int k = 0; k < 3; k++) begin
                    if (pcfg_ff[8*u + w][SLOT_W*k + SLOT_EN]) begin
                        nxt_out[u][w][pcfg_ff[8*u + w][SLOT_W*k +: 5]] =
                            (hit_ff[u][k] && pw_word_ff[u] == 3'(w))
                            ^ pcfg_ff[8*u + w][SLOT_W*k + SLOT_INV];
                    end
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            out_ff <= '0;
            warn_ff <= 2'h0;
        end else if (ce) begin
            out_ff <= nxt_out;
            for (int u = 0; u < 2; u++) begin
                warn_ff[u] <= panel_in[u].mode != MODE_COMPUTER;
            end
        end
    end

    assign ctl_out = out_ff;
    assign warn_lamp = warn_ff;

    // ************
    // register slave
    // ************
    logic aw_hold_ff;
    logic w_hold_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [1:0] rresp_ff;
    logic [31:0] rdata_ff;
    wire wr_go = aw_hold_ff && w_hold_ff && !bvalid_ff;
    wire wr_pcfg = awaddr_ff[7:6] == PAGE_PCFG;
    wire [3:0] wr_idx = awaddr_ff[5:2];
    wire [3:0] rd_idx = s_axi_araddr[5:2];
    wire rd_word = s_axi_araddr[7:6] == PAGE_WORD;
    wire rd_pcfg = s_axi_araddr[7:6] == PAGE_PCFG;
    wire rd_stat = s_axi_araddr == ADR_STATUS;
    wire rd_res = s_axi_araddr == ADR_RESULT;
    wire rd_ok = rd_word | rd_pcfg | rd_stat | rd_res;
    wire [31:0] stat_word = {8'h00, adc_busy, ready_ff, 2'(adc_st_ff != ADC_IDLE),
        cmd_ff};
    wire [31:0] rd_val = rd_stat ? stat_word :
        rd_res ? {8'h00, hin_ff} :
        rd_pcfg ? {11'h000, pcfg_ff[rd_idx]} :
        rd_word ? {8'h00, word_ff[rd_idx[3]][rd_idx[2:0]]} : 32'h00000000;

    assign s_axi_awready = !aw_hold_ff;
    assign s_axi_wready = !w_hold_ff;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rresp = rresp_ff;
    assign s_axi_rdata = rdata_ff;

    // aw and w in any order; answer after both
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h00000000;
            wstrb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
            for (int i = 0; i < 16; i++) begin
                pcfg_ff[i] <= PCFG_RST;
            end
        end else if (ce) begin
            if (s_axi_awvalid && !aw_hold_ff) begin
                aw_hold_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_hold_ff) begin
                w_hold_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_hold_ff <= 1'b0;
                w_hold_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_pcfg ? RESP_OKAY : RESP_SLVERR;
                if (wr_pcfg) begin
                    pcfg_ff[wr_idx] <= merge_bytes(pcfg_ff[wr_idx], wdata_ff, wstrb_ff);
                end
            end else if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rvalid_ff <= 1'b0;
            rresp_ff <= RESP_OKAY;
            rdata_ff <= 32'h00000000;
        end else if (ce) begin
            if (s_axi_arvalid && !rvalid_ff) begin
                rvalid_ff <= 1'b1;
                rresp_ff <= rd_ok ? RESP_OKAY : RESP_SLVERR;
                rdata_ff <= rd_val;
            end else if (rvalid_ff && s_axi_rready) begin
                rvalid_ff <= 1'b0;
            end
        end
    end

endmodule

// [verif/vcw_conv_model.sv]
`timescale 1ns/1ns
module vcw_conv_model (
    input wire logic clk, // system clock
    input wire logic adc_start, // start pulse
    input wire logic [3:0] adc_mux_sel, // analog input pick
    output logic adc_busy = 1'b0, // converting
    output logic [9:0] adc_result = 10'h000 // digital value
);
    int cnt = 0;
    always @(posedge clk) begin
        if (adc_start === 1'b1) begin
            adc_busy <= 1'b1;
            adc_result <= ~adc_result;
            cnt <= 166;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end else if (cnt == 1) begin
            cnt <= 0;
            adc_busy <= 1'b0;
            adc_result <= {adc_mux_sel, 6'h2A};
        end
    end
endmodule

// [verif/vcw_top_monitor.sv]
`timescale 1ns/1ns
module vcw_top_mon (
    input wire logic clk, // clock
    input wire logic sys_rst, // reset
    input wire logic command_word_strobe, // cmd
    input wire logic output_word_strobe, // data
    input wire logic [23:0] host_out_bus, // bus
    input wire logic host_input_ack, // ack
    input wire logic host_master_clear, // clear
    input wire logic transfer_accepted_pulse, // echo
    input wire logic input_ready_flag, // flag
    input wire logic [23:0] host_in_bus, // result
    input wire logic [3:0] adc_mux_sel, // mux
    input wire logic adc_start, // start
    input wire logic adc_busy, // busy
    input wire logic [9:0] adc_result, // raw result
    input wire vcw_pkg::vcw_panel_type [1:0] panel_in, // panels
    input wire logic [1:0] warn_lamp, // lamps
    input wire logic [1:0][7:0][23:0] ctl_out // control bits
);
    import vcw_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_cmd_echo: assert property ($rose(command_word_strobe) |=> transfer_accepted_pulse)
        else $error("command strobe not echoed");
    a_out_echo: assert property ($rose(output_word_strobe) |=> transfer_accepted_pulse)
        else $error("output strobe not echoed");
    a_echo_cause: assert property (transfer_accepted_pulse |->
        ($past(command_word_strobe) && !$past(command_word_strobe, 2))
        || ($past(output_word_strobe) && !$past(output_word_strobe, 2)))
        else $error("echo without strobe");
    a_mux_follow: assert property (command_word_strobe |=>
        adc_mux_sel == $past(host_out_bus[23:20])) else $error("input select wrong");
    a_start_delay: assert property ($rose(command_word_strobe) && host_out_bus[19]
        |-> ##[50:56] adc_start) else $error("converter not started");
    a_start_pulse: assert property (adc_start |=> !adc_start)
        else $error("start longer than a cycle");
    a_ready_set: assert property ($fell(adc_busy) |=> input_ready_flag
        && host_in_bus == {14'h0000, $past(adc_result)}) else $error("result not flagged");
    a_ack_clear: assert property (host_input_ack && !$fell(adc_busy)
        |=> !input_ready_flag) else $error("flag not cleared");
    a_flag_hold: assert property (input_ready_flag && !host_input_ack |=> input_ready_flag)
        else $error("flag dropped early");
    a_warn_lamp: assert property (warn_lamp ==
        {$past(panel_in[1].mode) != 2'h0, $past(panel_in[0].mode) != 2'h0})
        else $error("warning lamp wrong");
    a_clear_words: assert property (host_master_clear ##1 host_master_clear
        |=> ctl_out == '0) else $error("words not cleared");
endmodule
bind vcw_top vcw_top_mon vcw_top_mon_i (.clk, .sys_rst, .command_word_strobe,
    .output_word_strobe, .host_out_bus, .host_input_ack, .host_master_clear,
    .transfer_accepted_pulse, .input_ready_flag, .host_in_bus, .adc_mux_sel, .adc_start,
    .adc_busy, .adc_result, .panel_in, .warn_lamp, .ctl_out);

// [verif/vcw_top_bench.sv]
`timescale 1ns/1ns
module vcw_top_bench;
    import vcw_pkg::*;
    logic clk = 1'b0, sys_rst = 1'b1, ce = 1'b1, host_input_ack = 1'b0;
    logic command_word_strobe = 1'b0, output_word_strobe = 1'b0, host_master_clear = 1'b0;
    logic [23:0] host_out_bus = 24'h0, d, host_in_bus;
    vcw_panel_type [1:0] panel_in = '0;
    vcw_ext_type ext_in = '0;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, act, exp_v, rd_d;
    logic [3:0] s_axi_wstrb = 4'hF, adc_mux_sel;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, transfer_accepted_pulse;
    logic input_ready_flag, adc_start, adc_busy;
    logic [1:0] s_axi_bresp, s_axi_rresp, warn_lamp, r;
    logic [9:0] adc_result;
    logic [1:0][7:0][23:0] ctl_out;
    logic [31:0] exp_q[$];
    int err_total = 0, comparisons = 0, seed = 32'h1F54, hi_cnt = 0, acks = 0, xfers = 0;
    event got;
    vcw_top vcw_top_i (.clk, .sys_rst, .ce, .host_out_bus, .command_word_strobe,
        .output_word_strobe, .host_input_ack, .host_master_clear, .transfer_accepted_pulse,
        .input_ready_flag, .host_in_bus, .adc_mux_sel, .adc_start, .adc_busy, .adc_result,
        .panel_in, .ext_in, .warn_lamp, .ctl_out, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    vcw_conv_model vcw_conv_model_i (.clk, .adc_start, .adc_mux_sel, .adc_busy, .adc_result);
    always #50 clk = ~clk;
    always @(posedge clk) if (ctl_out[0][0][3] === 1'b1) hi_cnt++;
    always @(posedge clk) if (transfer_accepted_pulse === 1'b1) acks++;
    always @(got) begin
        exp_v = exp_q.pop_front();
        comparisons++;
        if (exp_v !== act) begin
            err_total++;
            $display("wrong value at %0t: expected %h got %h", $time, exp_v, act);
        end
    end
    task chk(input logic [31:0] e, a);
        exp_q.push_back(e);
        act = a;
        -> got;
        #1;
    endtask
    task put(input logic [23:0] cmd, dat);
        host_out_bus <= cmd;
        command_word_strobe <= 1'b1;
        @(posedge clk);
        command_word_strobe <= 1'b0;
        host_out_bus <= dat;
        @(posedge clk);
        output_word_strobe <= 1'b1;
        @(posedge clk);
        output_word_strobe <= 1'b0;
        repeat (3) @(posedge clk);
        xfers++;
    endtask
    task axi_wr(input logic [7:0] a, input logic [31:0] v);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready);
        do @(posedge clk); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task axi_rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (s_axi_rvalid !== 1'b1);
        r = s_axi_rresp;
        rd_d = s_axi_rdata;
        s_axi_rready <= 1'b0;
    endtask
    task end_sim;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #3000000;
        err_total++;
        end_sim;
    end
    initial begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 3; i++) begin
            d = 24'($random(seed));
            put({12'h0, 4'(3 & (1 << i)), 1'b0, 3'(7 - i), 4'h0}, d);
            chk(i == 0 ? d : 24'h0, ctl_out[0][7 - i]);
            chk(i == 1 ? d : 24'h0, ctl_out[1][7 - i]);
        end
        $display("computer load test done");
        d = 24'($random(seed));
        put({d[3:0], 20'h80000}, 24'h0);
        for (int n = 0; n < 400 && input_ready_flag !== 1'b1; n++) @(posedge clk);
        @(negedge clk);
        chk({14'h0, d[3:0], 6'h2A}, host_in_bus);
        chk(d[3:0], adc_mux_sel);
        @(posedge clk);
        host_input_ack <= 1'b1;
        @(posedge clk);
        host_input_ack <= 1'b0;
        @(negedge clk);
        chk(0, input_ready_flag);
        $display("conversion test done");
        @(posedge clk);
        axi_wr(8'h40, 32'h23);
        chk(RESP_OKAY, r);
        axi_rd(8'h40);
        chk(32'h23, rd_d);
        axi_rd(8'hFC);
        chk(RESP_SLVERR, r);
        axi_wr(ADR_RESULT, 32'h1);
        chk(RESP_SLVERR, r);
        hi_cnt = 0;
        put(24'h100, 24'h8);
        repeat (30) @(posedge clk);
        chk(PLS_WID_CYC, hi_cnt);
        $display("pulse test done");
        d = 24'($random(seed));
        panel_in[1].mode <= MODE_MANUAL;
        panel_in[1].data <= d;
        panel_in[1].addr <= 3'h3;
        panel_in[1].load <= 1'b1;
        repeat (30) @(posedge clk);
        panel_in[1].load <= 1'b0;
        repeat (30) @(posedge clk);
        chk(d, ctl_out[1][3]);
        panel_in[0].mode <= 2'h2;
        ext_in <= {d, 3'h2, 4'h1};
        put(24'h120, d);
        chk(0, ctl_out[0][2]);
        chk(2'h3, warn_lamp);
        panel_in[1].clr <= 1'b1;
        repeat (3) @(posedge clk);
        chk(0, ctl_out[1][3]);
        panel_in <= '0;
        host_master_clear <= 1'b1;
        repeat (3) @(posedge clk);
        chk(0, ctl_out[0][7]);
        host_master_clear <= 1'b0;
        @(posedge clk);
        chk(xfers * 2, acks);
        $display("panel test done");
        end_sim;
    end
endmodule
